// file: rtl/actr_top.sv
// Core timing and offset trim register bank with mode-driven trim selection
// How it works
// - Core B timing trim used only in single mode, calibration on, second input
// - Dual-mode first-input offset goes to core A when calibration is on
// - Dual-mode second-input offset goes to core A when calibration is on
// - Single-mode first-input offset goes to core A when calibration is on
// - Single-mode core A second input on 90-degree phase uses its own offset register
// - Offset registers are 16 bits, value 11:0, spare bits writable, reset zero
// - After reset every trim register loads its factory default from fuses
// - Core B first-input offset register holds core B correction, resets zero
// - Core B first-input offset used in both modes while calibration is on
// - Host may read back and overwrite every trim value
`timescale 1ns/100ps
module actr_top
  import actr_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  output logic      [DATA_W-1:0]   reg_rdata,
  output logic                     load_busy,
  // Fuse storage, read data one cycle after the address
  output logic      [2:0]          fuse_addr,
  input  wire logic [REG_W-1:0]    fuse_rdata,
  // Operating mode
  input  wire logic                single_mode,
  input  wire logic                fg_cal_en,
  input  wire logic                core_a_second_input,
  input  wire logic                core_b_second_input,
  input  wire logic                core_a_phase90,
  // Trims to the cores
  output logic                     core_a_offset_on,
  output logic      [OFFSET_W-1:0] core_a_offset,
  output logic                     core_b_offset_on,
  output logic      [OFFSET_W-1:0] core_b_offset,
  output logic                     core_b_timing_on,
  output logic      [TIMING_W-1:0] core_b_timing_trim
);

  actr_ld_state_t    ld_state_q;
  logic [2:0]        ld_idx_q;
  logic              cap_v_q;
  logic [2:0]        cap_idx_q;
  logic [15:0]       trim_q [NUM_TRIM];
  logic [NUM_TRIM-1:0] wr_lo;
  logic [NUM_TRIM-1:0] wr_hi;
  logic [NUM_TRIM-1:0] ld_en;
  logic              wr_ok;
  logic [7:0]        rdata_d;
  logic [7:0]        rdata_q;
  logic              a_dual1;
  logic              a_dual2;
  logic              a_sing1;
  logic              a_sing2;
  logic              a_apply;
  logic [15:0]       a_val;
  logic              b_apply;
  logic              t_apply;

  // Fuse load sequencer: one word per cycle, the port is busy until done
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ld_state_q <= LD_RUN;
      ld_idx_q   <= 3'h0;
    end
    else
    begin
      case (ld_state_q)
        LD_RUN:
        begin
          ld_idx_q <= ld_idx_q + 3'h1;
          if (ld_idx_q == IDX_LAST)
            ld_state_q <= LD_WAIT;
        end
        LD_WAIT:
          ld_state_q <= LD_DONE;
        LD_DONE:
          ld_state_q <= LD_DONE;
        default:
          ld_state_q <= LD_RUN;
      endcase
    end
  end

  // Capture strobe follows the address by one cycle, matching fuse latency
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_v_q   <= 1'b0;
      cap_idx_q <= 3'h0;
    end
    else
    begin
      cap_v_q   <= (ld_state_q == LD_RUN);
      cap_idx_q <= ld_idx_q;
    end
  end

  assign fuse_addr = ld_idx_q;
  assign load_busy = (ld_state_q != LD_DONE);
  assign wr_ok     = reg_wr & ~load_busy;

  // Register bank
  genvar g;
  generate
    for (g = 0; g < NUM_TRIM; g++)
    begin : g_trim
      localparam logic [15:0] WMASK = (g == 0) ? TIMING_MASK : FULL_MASK;
      localparam logic [15:0] FMASK = (g == 0) ? TIMING_MASK : OFFSET_MASK;
      assign ld_en[g] = cap_v_q & (cap_idx_q == 3'(g));
      assign wr_lo[g] = wr_ok & (reg_addr == TRIM_ADDR[g]);
      assign wr_hi[g] = wr_ok & (g != 0) & (reg_addr == TRIM_ADDR[g] + ADDR_HI_BYTE);
      actr_trim_reg #(
        .WR_MASK   (WMASK),
        .FUSE_MASK (FMASK)
      ) u_reg (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .load_en  (ld_en[g]),
        .load_val (fuse_rdata),
        .wr_lo    (wr_lo[g]),
        .wr_hi    (wr_hi[g]),
        .wr_data  (reg_wdata),
        .val_q    (trim_q[g])
      );
    end
  endgenerate

  // Read-back; unmapped bytes read zero
  always_comb
  begin
    rdata_d = RD_UNMAPPED;
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      if (reg_addr == TRIM_ADDR[i])
        rdata_d = trim_q[i][7:0];
      else if ((i != 0) && (reg_addr == TRIM_ADDR[i] + ADDR_HI_BYTE))
        rdata_d = trim_q[i][15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= RD_UNMAPPED;
    else if (reg_rd)
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // Core A offset choice; dual mode takes the second input before phase 90
  assign a_dual1 = ~single_mode & ~core_a_second_input;
  assign a_dual2 = ~single_mode & core_a_second_input;
  assign a_sing1 = single_mode & ~core_a_second_input;
  assign a_sing2 = single_mode & core_a_second_input & core_a_phase90;
  assign a_apply = fg_cal_en & (a_dual1 | a_dual2 | a_sing1 | a_sing2);

  always_comb
  begin
    a_val = 16'h0000;
    if (a_dual1)
      a_val = trim_q[IDX_A_DUAL1];
    else if (a_dual2)
      a_val = trim_q[IDX_A_DUAL2];
    else if (a_sing1)
      a_val = trim_q[IDX_A_SING1];
    else if (a_sing2)
      a_val = trim_q[IDX_A_SING2];
  end

  // Core B second-input offset is outside this bank, so it gets none here
  assign b_apply = fg_cal_en & ~core_b_second_input;
  assign t_apply = fg_cal_en & single_mode & core_b_second_input;

  actr_apply #(.W(OFFSET_W)) u_core_a_off (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .apply   (a_apply),
    .val     (a_val[OFFSET_W-1:0]),
    .on_q    (core_a_offset_on),
    .val_q   (core_a_offset)
  );

  actr_apply #(.W(OFFSET_W)) u_core_b_off (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .apply   (b_apply),
    .val     (trim_q[IDX_B_FIRST][OFFSET_W-1:0]),
    .on_q    (core_b_offset_on),
    .val_q   (core_b_offset)
  );

  actr_apply #(.W(TIMING_W)) u_core_b_tim (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .apply   (t_apply),
    .val     (trim_q[IDX_B_TIM][TIMING_W-1:0]),
    .on_q    (core_b_timing_on),
    .val_q   (core_b_timing_trim)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_host_wr_lo;
    wr_ok && (reg_addr == ADDR_CORE_A_OFFSET_DUAL_1ST);
  endsequence

  sequence s_host_rd_lo;
    reg_rd && !reg_wr && (reg_addr == ADDR_CORE_A_OFFSET_DUAL_1ST);
  endsequence

  // Busy is seen on five more edges after the first capture, then drops
  sequence s_load_run;
    load_busy [*6] ##1 !load_busy;
  endsequence

  fuse_timing_a: assert property (
    cap_v_q && (cap_idx_q == IDX_B_TIM)
    |=> trim_q[IDX_B_TIM] == ($past(fuse_rdata) & TIMING_MASK))
    else $error("timing trim did not take its fuse default");

  load_length_a: assert property (
    $rose(cap_v_q) |-> s_load_run)
    else $error("fuse load length wrong");

  rsvd_zero_a: assert property (
    $fell(load_busy) |-> (trim_q[IDX_A_DUAL1][RSVD_MSB:RSVD_LSB] == 4'h0)
      && (trim_q[IDX_B_FIRST][RSVD_MSB:RSVD_LSB] == 4'h0))
    else $error("reserved offset bits not zero after load");

  readback_a: assert property (
    s_host_wr_lo ##1 s_host_rd_lo |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written offset byte not read back");

  a_dual1_a: assert property (
    fg_cal_en && !single_mode && !core_a_second_input
    |=> core_a_offset_on && (core_a_offset == $past(trim_q[IDX_A_DUAL1][11:0])))
    else $error("core A dual first-input offset not applied");

  a_dual2_a: assert property (
    fg_cal_en && !single_mode && core_a_second_input
    |=> core_a_offset_on && (core_a_offset == $past(trim_q[IDX_A_DUAL2][11:0])))
    else $error("core A dual second-input offset not applied");

  a_sing1_a: assert property (
    fg_cal_en && single_mode && !core_a_second_input
    |=> core_a_offset == $past(trim_q[IDX_A_SING1][11:0]))
    else $error("core A single first-input offset not applied");

  a_phase90_a: assert property (
    fg_cal_en && single_mode && core_a_second_input && core_a_phase90
    |=> core_a_offset == $past(trim_q[IDX_A_SING2][11:0]))
    else $error("core A phase 90 offset not applied");

  b_first_a: assert property (
    fg_cal_en && !core_b_second_input
    |=> core_b_offset_on && (core_b_offset == $past(trim_q[IDX_B_FIRST][11:0])))
    else $error("core B first-input offset not applied");

  b_timing_a: assert property (
    $past(fg_cal_en && single_mode && core_b_second_input) != 1'b0
    || !core_b_timing_on)
    else $error("core B timing trim applied outside its mode");

  cal_off_a: assert property (
    !fg_cal_en |=> !core_a_offset_on && !core_b_offset_on && !core_b_timing_on
      && (core_a_offset == 12'h000) && (core_b_offset == 12'h000))
    else $error("trim applied while calibration off");

  load_lock_a: assert property (
    load_busy && !ld_en[IDX_B_TIM]
    |=> trim_q[IDX_B_TIM] == $past(trim_q[IDX_B_TIM]))
    else $error("timing trim changed during load");

  fuse_offset_a: assert property (
    cap_v_q && (cap_idx_q == IDX_B_FIRST)
    |=> trim_q[IDX_B_FIRST] == ($past(fuse_rdata) & OFFSET_MASK))
    else $error("core B offset did not take its fuse default");

  high_byte_a: assert property (
    wr_ok && (reg_addr == ADDR_CORE_B_OFFSET_1ST + ADDR_HI_BYTE)
    |=> trim_q[IDX_B_FIRST][15:8] == $past(reg_wdata))
    else $error("offset high byte not written");

  a_no_phase_a: assert property (
    fg_cal_en && single_mode && core_a_second_input && !core_a_phase90
    |=> !core_a_offset_on && (core_a_offset == 12'h000))
    else $error("core A offset applied without phase 90");

  b_second_a: assert property (
    core_b_second_input
    |=> !core_b_offset_on && (core_b_offset == 12'h000))
    else $error("core B offset applied on second input");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

endmodule

// file: rtl/actr_pkg.sv
// Constants, address map and types for the converter core trim register bank
package actr_pkg;

  // Register port geometry (byte-wide, byte-addressed)
  localparam int             ADDR_W      = 12;
  localparam int             DATA_W      = 8;
  localparam int             REG_W       = 16;
  localparam int             OFFSET_W    = 12;
  localparam int             TIMING_W    = 8;
  localparam int             NUM_TRIM    = 6;

  // Printed byte addresses; a 16-bit register also owns the next byte up
  localparam logic [11:0]    ADDR_CORE_B_TIMING_SINGLE_2ND = 12'h31B;
  localparam logic [11:0]    ADDR_CORE_A_OFFSET_DUAL_1ST   = 12'h344;
  localparam logic [11:0]    ADDR_CORE_A_OFFSET_DUAL_2ND   = 12'h346;
  localparam logic [11:0]    ADDR_CORE_A_OFFSET_SINGLE_1ST = 12'h348;
  localparam logic [11:0]    ADDR_CORE_A_OFFSET_SINGLE_2ND = 12'h34A;
  localparam logic [11:0]    ADDR_CORE_B_OFFSET_1ST        = 12'h34C;
  localparam logic [11:0]    ADDR_HI_BYTE                  = 12'h001;

  // Bank index of each register, also its fuse storage word address
  localparam logic [2:0]     IDX_B_TIM    = 3'h0;
  localparam logic [2:0]     IDX_A_DUAL1  = 3'h1;
  localparam logic [2:0]     IDX_A_DUAL2  = 3'h2;
  localparam logic [2:0]     IDX_A_SING1  = 3'h3;
  localparam logic [2:0]     IDX_A_SING2  = 3'h4;
  localparam logic [2:0]     IDX_B_FIRST  = 3'h5;
  localparam logic [2:0]     IDX_LAST     = 3'h5;

  localparam logic [11:0]    TRIM_ADDR [NUM_TRIM] = '{
    ADDR_CORE_B_TIMING_SINGLE_2ND, ADDR_CORE_A_OFFSET_DUAL_1ST,
    ADDR_CORE_A_OFFSET_DUAL_2ND, ADDR_CORE_A_OFFSET_SINGLE_1ST,
    ADDR_CORE_A_OFFSET_SINGLE_2ND, ADDR_CORE_B_OFFSET_1ST};

  // Field layout and reset values
  localparam logic [15:0]    RESET_VAL    = 16'h0000;
  localparam logic [15:0]    TIMING_MASK  = 16'h00FF;
  localparam logic [15:0]    OFFSET_MASK  = 16'h0FFF;
  localparam logic [15:0]    FULL_MASK    = 16'hFFFF;
  localparam int             RSVD_MSB     = 15;
  localparam int             RSVD_LSB     = 12;
  localparam logic [7:0]     RD_UNMAPPED  = 8'h00;

  // Fuse load sequencer
  typedef enum logic [1:0] {
    LD_RUN  = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } actr_ld_state_t;

endpackage

// file: rtl/actr_trim_reg.sv
// One trim register: reset to zero, fuse default load, host byte writes
`timescale 1ns/100ps
module actr_trim_reg
  import actr_pkg::*;
#(
  parameter logic [15:0] WR_MASK   = 16'hFFFF,
  parameter logic [15:0] FUSE_MASK = 16'hFFFF
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Fuse default load
  input  wire logic        load_en,
  input  wire logic [15:0] load_val,
  // Host byte writes
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wr_data,
  // Stored value
  output logic      [15:0] val_q
);

  logic [15:0] val_d;

  always_comb
  begin
    val_d = val_q;
    if (wr_lo)
      val_d[7:0] = wr_data;
    if (wr_hi)
      val_d[15:8] = wr_data;
    val_d = val_d & WR_MASK;
  end

  // Load wins: the host port is closed while the sequencer runs anyway
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      val_q <= RESET_VAL;
    else if (load_en)
      val_q <= load_val & FUSE_MASK;
    else
      val_q <= val_d;
  end

endmodule

// file: rtl/actr_apply.sv
// Registered gate that passes a trim value to a core only when it applies
`timescale 1ns/100ps
module actr_apply
  import actr_pkg::*;
#(
  parameter int W = 12
)
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Selected value
  input  wire logic         apply,
  input  wire logic [W-1:0] val,
  // To the core
  output logic              on_q,
  output logic      [W-1:0] val_q
);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_q  <= 1'b0;
      val_q <= '0;
    end
    else
    begin
      on_q  <= apply;
      val_q <= apply ? val : '0;
    end
  end

endmodule

// file: verification/actr_fuse_model.sv
// Fuse storage model holding the factory trim defaults
`timescale 1ns/100ps
module actr_fuse_model
  import actr_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Fuse read port
  input  wire logic [2:0]  fuse_addr,
  output logic      [15:0] fuse_rdata
);
  logic [15:0] junk_q = 16'h5A5A;

  // Outside the six words the data wanders, so a late sample cannot pass
  always @(posedge ref_clk)
  begin
    junk_q <= ~junk_q + 16'h0001;
  end

  // One cycle of read latency; spare bits set on purpose so their dropping shows up
  always @(posedge ref_clk)
  begin
    if (fuse_addr <= IDX_LAST)
    begin
      fuse_rdata <= 16'hF000 | (16'h0101 * ({13'h0, fuse_addr} + 16'h0001));
    end
    else
    begin
      fuse_rdata <= junk_q;
    end
  end
endmodule

// file: verification/actr_top_tb_top.sv
// Self-checking bench for the core trim register bank
`timescale 1ns/100ps
module actr_top_tb_top
  import actr_pkg::*;
;
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = 12'h000;
  logic [DATA_W-1:0]   reg_wdata = 8'h00;
  logic [DATA_W-1:0]   reg_rdata;
  logic                load_busy;
  logic [2:0]          fuse_addr;
  logic [REG_W-1:0]    fuse_rdata;
  logic [4:0]          mode = 5'h00;
  logic                a_on;
  logic                b_on;
  logic                t_on;
  logic [OFFSET_W-1:0] a_off;
  logic [OFFSET_W-1:0] b_off;
  logic [TIMING_W-1:0] t_trim;
  logic [15:0]         regv [NUM_TRIM];
  int                  n_errors = 0;
  int                  check_count = 0;

  always #5 ref_clk = ~ref_clk;

  actr_top u_actr_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .load_busy(load_busy), .fuse_addr(fuse_addr), .fuse_rdata(fuse_rdata),
    .single_mode(mode[4]), .fg_cal_en(mode[3]), .core_a_second_input(mode[2]),
    .core_b_second_input(mode[1]), .core_a_phase90(mode[0]),
    .core_a_offset_on(a_on), .core_a_offset(a_off), .core_b_offset_on(b_on),
    .core_b_offset(b_off), .core_b_timing_on(t_on), .core_b_timing_trim(t_trim));

  actr_fuse_model u_actr_fuse_model (
    .ref_clk(ref_clk), .fuse_addr(fuse_addr), .fuse_rdata(fuse_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Low byte then high byte on consecutive edges
  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d[7:0];
    @(posedge ref_clk);
    reg_addr <= a + ADDR_HI_BYTE;
    reg_wdata <= d[15:8];
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd16(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_addr <= a + ADDR_HI_BYTE;
    #1 d[7:0] = reg_rdata;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d[15:8] = reg_rdata;
  endtask

  task automatic check_all(input string what);
    logic [15:0] d;
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      rd16(TRIM_ADDR[i], d);
      chk(d, regv[i], what);
    end
  endtask

  // Reset in mid-run as well: fuse defaults must come back
  task automatic reset_load();
    int n;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk({load_busy, reg_rdata, a_on, b_on, t_on}, 16'h0800, "reset state");
    chk({4'h0, a_off | b_off | {4'h0, t_trim}}, 16'h0000, "trims in reset");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // A write in mid-load must be refused, after the timing word has landed
    repeat (3) @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_CORE_B_TIMING_SINGLE_2ND;
    reg_wdata <= 8'h77;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    n = 4;
    while (load_busy !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk({15'h0, load_busy}, 16'h0000, "load finished");
    chk(16'(n), 16'h0007, "load length");
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      regv[i] = (16'h0101 * (i + 1)) & ((i == 0) ? TIMING_MASK : OFFSET_MASK);
    end
    check_all("fuse default");
  endtask

  // Every register, reserved bits included; the byte above the timing trim is dead
  task automatic rw_all();
    logic [15:0] d;
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      d = 16'hC0DE ^ (16'h1111 * i);
      wr16(TRIM_ADDR[i], d);
      regv[i] = d & ((i == 0) ? TIMING_MASK : FULL_MASK);
    end
    wr16(12'h000, 16'hFFFF);
    check_all("write back");
    rd16(12'h000, d);
    chk(d, 16'h0000, "unmapped read");
  endtask

  // Write a byte, then read it back on the very next edge
  task automatic wr_then_rd();
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_CORE_A_OFFSET_DUAL_1ST;
    reg_wdata <= 8'hA5;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, 16'h00A5, "read after write");
    regv[1][7:0] = 8'hA5;
  endtask

  // All 32 mode combinations against the selection table
  task automatic modes();
    logic s, f, a2, b2, p, ao, bo, to;
    int ia;
    for (int k = 0; k < 32; k++)
    begin
      @(posedge ref_clk);
      mode <= 5'(k);
      {s, f, a2, b2, p} = 5'(k);
      repeat (2) @(posedge ref_clk);
      ia = s ? (a2 ? 4 : 3) : (a2 ? 2 : 1);
      ao = f && (!(s && a2) || p);
      bo = f && !b2;
      to = f && s && b2;
      #1 chk({a_on, 3'h0, a_off}, {ao, 3'h0, ao ? regv[ia][11:0] : 12'h000}, "core a");
      chk({b_on, 3'h0, b_off}, {bo, 3'h0, bo ? regv[5][11:0] : 12'h000}, "core b");
      chk({7'h00, t_on, t_trim}, {7'h00, to, to ? regv[0][7:0] : 8'h00}, "timing");
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  initial
  begin
    reset_load();
    rw_all();
    wr_then_rd();
    modes();
    reset_load();
    conclude();
  end
endmodule
